/* rtl/delay_timer_pkg.sv */
// Purpose: shared constants and types of the delay timer unit
// Assumes: 100 MHz ref_clk, timing base of 10 ms ticks
// Notes:   all spans are held as counts of 10 ms ticks
package delay_timer_pkg;

    // clock and tick timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 10_000_000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // widths
    localparam int CNT_W   = 26;
    localparam int FIELD_W = 7;
    localparam int REF_W   = 18;
    localparam int REF_NUM = 8;
    localparam int SEL_W   = 3;
    localparam int SYNC_N  = 3;

    // stored-constant field limits
    localparam int MAJOR_MAX     = 99;
    localparam int MINOR_MAX_SEC = 99;
    localparam int MINOR_MAX_60  = 59;

    // live-value limits
    localparam int REF_MAX_MS  = 99990;
    localparam int REF_MAX_SEC = 5999;
    localparam int REF_MAX_MIN = 5999;

    // unit conversion into ticks
    localparam int MS_PER_TICK  = 10;
    localparam int TICKS_PER_S  = 100;
    localparam int SEC_PER_MIN  = 60;
    localparam int TICKS_PER_M  = 6000;

    // synchroniser lane positions
    localparam int LN_LAUNCH = 0;
    localparam int LN_CLEAR  = 1;
    localparam int LN_PFAIL  = 2;

    localparam logic [CNT_W-1:0] COUNT_RST = 26'h0000000;

    typedef enum logic [1:0] {
        MODE_ON    = 2'h0,
        MODE_OFF   = 2'h1,
        MODE_ONOFF = 2'h2
    } mode_t;

    typedef enum logic [1:0] {
        BASE_SEC  = 2'h0,
        BASE_MIN  = 2'h1,
        BASE_HOUR = 2'h2
    } param_base_t;

    typedef enum logic [1:0] {
        UNIT_MS  = 2'h0,
        UNIT_SEC = 2'h1,
        UNIT_MIN = 2'h2
    } ref_unit_t;

    typedef enum logic {
        RET_NONE = 1'b0,
        RET_KEEP = 1'b1
    } retain_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_HI_WAIT = 4'h2,
        ST_ON      = 4'h4,
        ST_LO_WAIT = 4'h8
    } timer_state_t;

endpackage

/* rtl/tick_gen.sv */
// Purpose: periodic one-cycle tick that paces every elapsed count
// Assumes: TICK_CYCLES is at least 2
// Notes:   tick phase is free running, so a span may end up to one
//          tick early relative to the launch edge
`timescale 1ns/1ns
`default_nettype none
module tick_gen
    import delay_timer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    output logic      tick
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic          tick;
    } tick_st_t;

    tick_st_t st_r;
    tick_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == LAST) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + TW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

/* rtl/span_select.sv */
// Purpose: turn one span setting into a count of 10 ms ticks
// Assumes: ref_values holds REF_NUM signed live values, lane 0 lowest
// Notes:   out-of-range inputs saturate, they are never rejected
`timescale 1ns/1ns
`default_nettype none
module span_select
    import delay_timer_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     src_ref,
    input  wire param_base_t              base,
    input  wire logic [FIELD_W-1:0]       major,
    input  wire logic [FIELD_W-1:0]       minor,
    input  wire logic [SEL_W-1:0]         block_sel,
    input  wire ref_unit_t                unit,
    input  wire logic [REF_NUM*REF_W-1:0] ref_values,
    output logic      [CNT_W-1:0]         span
);
    typedef struct packed {
        logic [CNT_W-1:0] span;
    } span_st_t;

    span_st_t st_r;
    span_st_t st_nxt;

    // saturate a signed live value into 0..mx
    function automatic logic [CNT_W-1:0] clamp_ref(
        input logic signed [REF_W-1:0] v,
        input int                      mx
    );
        logic [CNT_W-1:0] r;
        r = '0;
        if (v < 0) begin
            r = '0;
        end else if (int'(v) > mx) begin
            r = CNT_W'(mx); // R8
        end else begin
            r = CNT_W'(unsigned'(v));
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] clamp_field(
        input logic [FIELD_W-1:0] v,
        input int                 mx
    );
        logic [CNT_W-1:0] r;
        r = CNT_W'(v);
        if (int'(v) > mx) begin
            r = CNT_W'(mx); // R6
        end
        return r;
    endfunction

    logic signed [REF_W-1:0] live;
    logic [CNT_W-1:0]        maj;
    logic [CNT_W-1:0]        mnr;

    assign live = ref_values[block_sel*REF_W +: REF_W];

    always_comb begin
        st_nxt = st_r;
        maj = clamp_field(major, MAJOR_MAX);
        mnr = clamp_field(minor,
            (base == BASE_SEC) ? MINOR_MAX_SEC : MINOR_MAX_60);
        if (src_ref) begin // R9
            case (unit) // R7
                UNIT_MS: st_nxt.span =
                    clamp_ref(live, REF_MAX_MS) / CNT_W'(MS_PER_TICK);
                UNIT_SEC: st_nxt.span =
                    clamp_ref(live, REF_MAX_SEC) * CNT_W'(TICKS_PER_S);
                UNIT_MIN: st_nxt.span =
                    clamp_ref(live, REF_MAX_MIN) * CNT_W'(TICKS_PER_M);
                default: st_nxt.span = '0;
            endcase
        end else begin
            case (base) // R6
                BASE_SEC: st_nxt.span =
                    maj * CNT_W'(TICKS_PER_S) + mnr;
                BASE_MIN: st_nxt.span =
                    (maj * CNT_W'(SEC_PER_MIN) + mnr)
                    * CNT_W'(TICKS_PER_S);
                BASE_HOUR: st_nxt.span =
                    (maj * CNT_W'(SEC_PER_MIN) + mnr)
                    * CNT_W'(TICKS_PER_M);
                default: st_nxt.span = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign span = st_r.span;
endmodule
`default_nettype wire

/* rtl/delay_timer_unit.sv */
// Purpose: on-delay, off-delay and on/off-delay timer on one launch input
// Assumes: launch_in, clear_in, power_fail_in are asynchronous pins;
//          all other inputs are synchronous to ref_clk
// Notes:   power_fail_in high models supply loss; its release is the
//          restore point where retention is applied
// Behaviour
// [R1] on-delay: output rises only after launch stayed high for full span
// [R2] on-delay: launch falling early clears the elapsed count
// [R3] on-delay: output is 0 whenever launch is low
// [R4] after power failure, no retention clears output and count; else kept
// [R5] retention setting per instance: none or retained
// [R6] stored span in seconds, minutes or hours with printed limits
// [R7] live span read as ms, s or min with printed maxima
// [R8] out-of-range live values saturate to the nearest valid value
// [R9] each span from stored constant or selected block's live value
// [R10] off-delay: output rises at once with launch
// [R11] off-delay: count restarts at launch fall, output stays high
// [R12] off-delay: output drops when elapsed count reaches the span
// [R13] off-delay: new launch pulse retriggers the timing
// [R14] off-delay: clear zeroes the count and output at once
// [R15] on/off: rise starts high delay, output 1 if launch held
// [R16] on/off: early fall clears the high delay count
// [R17] on/off: fall starts low delay, output 0 if launch stays low
// [R18] on/off: early rise clears the low delay count
// [R19] count advances on a 10 ms tick and is compared every tick
`timescale 1ns/1ns
`default_nettype none
module delay_timer_unit
    import delay_timer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     launch_in,
    input  wire logic                     clear_in,
    input  wire logic                     power_fail_in,
    input  wire mode_t                    mode_sel,
    input  wire retain_t                  retain_sel,
    input  wire logic                     hi_src_ref,
    input  wire param_base_t              hi_base,
    input  wire logic [FIELD_W-1:0]       hi_major,
    input  wire logic [FIELD_W-1:0]       hi_minor,
    input  wire logic [SEL_W-1:0]         hi_block_sel,
    input  wire ref_unit_t                hi_unit,
    input  wire logic                     lo_src_ref,
    input  wire param_base_t              lo_base,
    input  wire logic [FIELD_W-1:0]       lo_major,
    input  wire logic [FIELD_W-1:0]       lo_minor,
    input  wire logic [SEL_W-1:0]         lo_block_sel,
    input  wire ref_unit_t                lo_unit,
    input  wire logic [REF_NUM*REF_W-1:0] ref_values,
    output logic                          q_out,
    output logic      [CNT_W-1:0]         elapsed_count,
    output logic                          timing_active
);
    typedef struct packed {
        logic [SYNC_N-1:0] s1;
        logic [SYNC_N-1:0] s2;
        logic [SYNC_N-1:0] s3;
        logic [SYNC_N-1:0] filt;
        logic [SYNC_N-1:0] prev;
        mode_t             mode;
        timer_state_t      state;
        logic              q;
        logic [CNT_W-1:0]  count;
    } timer_st_t;

    timer_st_t        st_r;
    timer_st_t        st_nxt;
    logic             tick;
    logic [CNT_W-1:0] high_delay;
    logic [CNT_W-1:0] low_delay;
    logic [CNT_W-1:0] span_cur;
    logic             launch_f;
    logic             launch_rise;
    logic             launch_fall;
    logic             clear_f;
    logic             pf_active;
    logic             pf_restore;
    logic             expired;
    logic             normal;

    tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tick   (tick)
    );

    // high_delay doubles as the single span of on- and off-delay modes
    span_select u_span_hi (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .src_ref   (hi_src_ref),
        .base      (hi_base),
        .major     (hi_major),
        .minor     (hi_minor),
        .block_sel (hi_block_sel),
        .unit      (hi_unit),
        .ref_values(ref_values),
        .span      (high_delay)
    );

    span_select u_span_lo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .src_ref   (lo_src_ref),
        .base      (lo_base),
        .major     (lo_major),
        .minor     (lo_minor),
        .block_sel (lo_block_sel),
        .unit      (lo_unit),
        .ref_values(ref_values),
        .span      (low_delay)
    );

    assign launch_f    = st_r.filt[LN_LAUNCH];
    assign launch_rise = st_r.filt[LN_LAUNCH] & ~st_r.prev[LN_LAUNCH];
    assign launch_fall = ~st_r.filt[LN_LAUNCH] & st_r.prev[LN_LAUNCH];
    assign clear_f     = st_r.filt[LN_CLEAR];
    assign pf_active   = st_r.filt[LN_PFAIL];
    assign pf_restore  = ~st_r.filt[LN_PFAIL] & st_r.prev[LN_PFAIL];
    assign normal      = ~pf_active & ~pf_restore & (mode_sel == st_r.mode);
    assign span_cur    = (st_r.mode == MODE_ONOFF && st_r.state == ST_LO_WAIT)
                         ? low_delay : high_delay;
    assign expired     = st_r.count >= span_cur; // R19

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {power_fail_in, clear_in, launch_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // a lane only changes once the second and third stage agree
        for (int i = 0; i < SYNC_N; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.filt[i] = st_r.s3[i];
            end
        end
        st_nxt.prev = st_r.filt;
        st_nxt.mode = mode_sel;
        if (pf_restore) begin
            if (retain_sel == RET_NONE) begin // R4 R5
                st_nxt.state = ST_IDLE;
                st_nxt.q = 1'b0;
                st_nxt.count = COUNT_RST;
            end
        end else if (pf_active) begin
            // supply gone: the timing state stays frozen
            st_nxt.state = st_r.state;
        end else if (mode_sel != st_r.mode) begin
            st_nxt.state = ST_IDLE;
            st_nxt.q = 1'b0;
            st_nxt.count = COUNT_RST;
        end else begin
            case (st_r.state)
                ST_IDLE: begin
                    st_nxt.count = COUNT_RST;
                    if (st_r.mode == MODE_OFF) begin
                        if (!clear_f && launch_rise) begin
                            st_nxt.state = ST_ON; // R10
                            st_nxt.q = 1'b1;
                        end
                    end else if (st_r.mode == MODE_ON ? launch_f
                                                       : launch_rise) begin
                        st_nxt.state = ST_HI_WAIT; // R15
                    end
                end
                ST_HI_WAIT: begin
                    if (!launch_f) begin
                        st_nxt.state = ST_IDLE; // R2 R16
                        st_nxt.count = COUNT_RST;
                        st_nxt.q = 1'b0;
                    end else if (expired) begin
                        st_nxt.state = ST_ON; // R1 R15
                        st_nxt.q = 1'b1;
                        st_nxt.count = COUNT_RST;
                    end else if (tick) begin
                        st_nxt.count = st_r.count + CNT_W'(1); // R19
                    end
                end
                ST_ON: begin
                    if (st_r.mode == MODE_OFF && clear_f) begin
                        st_nxt.state = ST_IDLE; // R14
                        st_nxt.q = 1'b0;
                        st_nxt.count = COUNT_RST;
                    end else if (st_r.mode == MODE_ON) begin
                        if (!launch_f) begin
                            st_nxt.state = ST_IDLE; // R3
                            st_nxt.q = 1'b0;
                        end
                    end else if (launch_fall) begin
                        st_nxt.state = ST_LO_WAIT; // R11 R17
                        st_nxt.count = COUNT_RST;
                    end
                end
                ST_LO_WAIT: begin
                    if (st_r.mode == MODE_OFF && clear_f) begin
                        st_nxt.state = ST_IDLE; // R14
                        st_nxt.q = 1'b0;
                        st_nxt.count = COUNT_RST;
                    end else if (launch_rise) begin
                        st_nxt.state = ST_ON; // R13 R18
                        st_nxt.count = COUNT_RST;
                    end else if (expired) begin
                        st_nxt.state = ST_IDLE; // R12 R17
                        st_nxt.q = 1'b0;
                        st_nxt.count = COUNT_RST;
                    end else if (tick) begin
                        st_nxt.count = st_r.count + CNT_W'(1); // R19
                    end
                end
                default: begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.q = 1'b0;
                    st_nxt.count = COUNT_RST;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{s1: '0, s2: '0, s3: '0, filt: '0, prev: '0,
                      mode: MODE_ON, state: ST_IDLE, q: 1'b0,
                      count: COUNT_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out         = st_r.q;
    assign elapsed_count = st_r.count;
    assign timing_active = st_r.state[1] | st_r.state[3];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    chk_on_low_zero: assert property ( // R3
        normal && st_r.mode == MODE_ON && !launch_f |=> !q_out)
        else $error("on-delay output high with launch low");
    chk_on_rise_held: assert property ( // R1
        st_r.mode == MODE_ON && $rose(q_out) |->
            $past(launch_f) && $past(launch_f, 2))
        else $error("on-delay output rose without held launch");
    chk_on_fall_count: assert property ( // R2
        normal && st_r.mode == MODE_ON && st_r.state == ST_HI_WAIT
        && !launch_f |=> elapsed_count == '0 && !q_out)
        else $error("on-delay count not cleared on early fall");
    chk_off_rise_set: assert property ( // R10
        normal && st_r.mode == MODE_OFF && launch_rise && !clear_f
        |=> q_out)
        else $error("off-delay output not set at launch rise");
    chk_off_fall_hold: assert property ( // R11
        normal && st_r.mode == MODE_OFF && st_r.state == ST_ON
        && launch_fall && !clear_f |=> q_out && elapsed_count == '0)
        else $error("off-delay count not restarted at fall");
    chk_off_expire_drop: assert property ( // R12
        normal && st_r.mode == MODE_OFF && st_r.state == ST_LO_WAIT
        && expired && !launch_rise && !clear_f |=> !q_out)
        else $error("off-delay output held past span");
    chk_off_clear_now: assert property ( // R14
        normal && st_r.mode == MODE_OFF && clear_f
        |=> !q_out && elapsed_count == '0)
        else $error("clear did not zero output and count");
    chk_onoff_lo_cut: assert property ( // R18
        normal && st_r.mode == MODE_ONOFF && st_r.state == ST_LO_WAIT
        && launch_rise |=> q_out && elapsed_count == '0)
        else $error("low delay not cut by early rise");
    chk_off_retrig: assert property ( // R13
        normal && st_r.mode == MODE_OFF && st_r.state == ST_LO_WAIT
        && launch_rise && !clear_f |=> q_out && elapsed_count == '0)
        else $error("off-delay timing not retriggered");
    chk_onoff_hi_end: assert property ( // R15
        normal && st_r.mode == MODE_ONOFF && st_r.state == ST_HI_WAIT
        && launch_f && expired |=> q_out)
        else $error("on/off output not set after high delay");
    chk_onoff_hi_cut: assert property ( // R16
        normal && st_r.mode == MODE_ONOFF && st_r.state == ST_HI_WAIT
        && !launch_f |=> elapsed_count == '0 && !q_out)
        else $error("high delay not cleared by early fall");
    chk_onoff_lo_end: assert property ( // R17
        normal && st_r.mode == MODE_ONOFF && st_r.state == ST_LO_WAIT
        && expired && !launch_rise |=> !q_out)
        else $error("on/off output held past low delay");
    chk_pf_no_keep: assert property ( // R4
        pf_restore && retain_sel == RET_NONE
        |=> !q_out && elapsed_count == '0)
        else $error("state survived power failure without retention");
    chk_pf_keep: assert property ( // R4
        pf_active ##1 pf_restore && retain_sel == RET_KEEP
        |=> $stable(q_out) && $stable(elapsed_count))
        else $error("retained state lost at power restore");
    chk_count_tick: assert property ( // R19
        elapsed_count > $past(elapsed_count) |->
            $past(tick) && elapsed_count == $past(elapsed_count) + 1)
        else $error("elapsed count moved without a tick");

    cov_on_expire: cover property (
        st_r.mode == MODE_ON && $rose(q_out));
    cov_off_retrig: cover property (
        st_r.mode == MODE_OFF && st_r.state == ST_LO_WAIT && launch_rise);
    cov_onoff_drop: cover property (
        st_r.mode == MODE_ONOFF && $fell(q_out));
    cov_pf_keep: cover property (
        pf_restore && retain_sel == RET_KEEP && timing_active);
endmodule
`default_nettype wire

/* sim/live_value_source.sv */
// Purpose: live-value source that feeds the timer's reference lanes
// Assumes: lanes are 18-bit signed values, lane 0 lowest
// Notes:   a new value lands on a clock edge, as a block output would
`timescale 1ns/1ns
`default_nettype none
module live_value_source
    import delay_timer_pkg::*;
(
    input  wire logic                     ref_clk,
    output logic      [REF_NUM*REF_W-1:0] ref_values
);
    logic [REF_W-1:0] lane_r [REF_NUM];

    initial begin
        for (int k = 0; k < REF_NUM; k++) begin
            lane_r[k] = '0;
        end
    end

    task automatic set_lane(input int k, input int v);
        @(posedge ref_clk);
        lane_r[k] <= v[REF_W-1:0];
    endtask

    always_comb begin
        for (int k = 0; k < REF_NUM; k++) begin
            ref_values[k*REF_W +: REF_W] = lane_r[k];
        end
    end
endmodule
`default_nettype wire

/* sim/tb_delay_timer_unit.sv */
// Purpose: self-checking bench for the delay timer unit
// Assumes: a 4-cycle tick so that spans finish quickly
// Notes:   pin sync and free tick phase blur edges by about a tick,
//          so each check sits a tick clear of the expected edge
`timescale 1ns/1ns
`default_nettype none
module tb_delay_timer_unit
    import delay_timer_pkg::*;
;
    localparam int TC = 4;
    logic                     ref_clk, reset_n, launch_in, clear_in;
    logic                     power_fail_in, q_out, timing_active;
    mode_t                    mode_sel;
    retain_t                  retain_sel;
    logic                     hi_src_ref, lo_src_ref;
    param_base_t              hi_base, lo_base;
    logic [FIELD_W-1:0]       hi_major, hi_minor, lo_major, lo_minor;
    logic [SEL_W-1:0]         hi_block_sel, lo_block_sel;
    ref_unit_t                hi_unit, lo_unit;
    logic [REF_NUM*REF_W-1:0] ref_values;
    logic [CNT_W-1:0]         elapsed_count;
    int                       err_total, checked, cycles, seed, hs, ls;
    int                       lane_m [REF_NUM];
    // span table: src, base, major, minor, lane, unit
    int tbl[$] = '{1,0,0,0,0,0, 1,0,0,0,1,1, 1,0,0,0,2,0,
                   0,0,0,120,0,0, 0,1,0,1,0,0, 0,2,0,1,0,0};

    delay_timer_unit #(.TICK_CYCLES(TC)) DUT (.*);
    live_value_source src (.ref_clk(ref_clk), .ref_values(ref_values));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            test_done();
        end
    end

    // saturation picks the nearest legal value, never a rejection
    function automatic int span_of(input int s, b, mj, mn, sel, u);
        int v;
        v = lane_m[sel];
        mj = (mj > 99) ? 99 : mj;
        if (s == 0 && b == 0) return mj * 100 + ((mn > 99) ? 99 : mn);
        mn = (mn > 59) ? 59 : mn;
        if (s == 0) return (mj * 60 + mn) * ((b == 1) ? 100 : 6000);
        if (v < 0) return 0;
        if (u == 0) return ((v > 99990) ? 99990 : v) / 10;
        v = (v > 5999) ? 5999 : v;
        return v * ((u == 1) ? 100 : 6000);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic drive(input logic v);
        @(posedge ref_clk);
        launch_in <= v;
    endtask

    task automatic chk_q(input logic exp);
        @(negedge ref_clk);
        checked++;
        if (q_out !== exp) begin
            err_total++;
            $display("mismatch t=%0t q %h exp %h", $time, q_out, exp);
        end
    endtask

    task automatic chk_cnt(input logic [CNT_W-1:0] exp);
        @(negedge ref_clk);
        checked++;
        if (elapsed_count !== exp) begin
            err_total++;
            $display("mismatch t=%0t cnt %h exp %h", $time, elapsed_count,
                     exp);
        end
    endtask

    task automatic chk_act(input logic exp);
        @(negedge ref_clk);
        checked++;
        if (timing_active !== exp) begin
            err_total++;
            $display("mismatch t=%0t act %h exp %h", $time, timing_active,
                     exp);
        end
    endtask

    task automatic set_hi(input int s, b, mj, mn, sel, u);
        @(posedge ref_clk);
        hi_src_ref   <= s[0];
        hi_base      <= param_base_t'(b[1:0]);
        hi_major     <= mj[FIELD_W-1:0];
        hi_minor     <= mn[FIELD_W-1:0];
        hi_block_sel <= sel[SEL_W-1:0];
        hi_unit      <= ref_unit_t'(u[1:0]);
        hs = span_of(s, b, mj, mn, sel, u);
    endtask

    // output must stay low a tick before the span and be high after it
    task automatic on_run(input int s);
        drive(1'b1);
        if (s > 0) begin
            cyc((s - 1) * TC);
            chk_q(1'b0);
            chk_act(1'b1);
        end
        cyc(TC + 8);
        chk_q(1'b1);
        chk_cnt('0);
        chk_act(1'b0);
    endtask

    task automatic test_done();
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        seed = 99045;
        err_total = 0;
        checked = 0;
        cycles = 0;
        reset_n = 1'b0;
        launch_in = 1'b0;
        clear_in = 1'b0;
        power_fail_in = 1'b0;
        mode_sel = MODE_ON;
        retain_sel = RET_NONE;
        hi_src_ref = 1'b0;
        hi_base = BASE_SEC;
        hi_major = '0;
        hi_minor = '0;
        hi_block_sel = '0;
        hi_unit = UNIT_MS;
        lo_src_ref = 1'b1;
        lo_base = BASE_SEC;
        lo_major = '0;
        lo_minor = '0;
        lo_block_sel = '0;
        lo_unit = UNIT_MS;
        cyc(16);
        reset_n <= 1'b1;
        cyc(2);
        chk_q(1'b0);
        chk_cnt('0);
        for (int k = 0; k < REF_NUM; k++) begin
            lane_m[k] = (k == 0) ? 50 : (k == 1) ? 1 : (k == 2) ? -7
                      : $random(seed) % 1000;
            src.set_lane(k, lane_m[k]);
        end
        ls = span_of(1, 0, 0, 0, 0, 0);
        set_hi(0, 0, 0, 3 + ($random(seed) & 7), 0, 0);
        on_run(hs);
        drive(1'b0);
        cyc(8);
        chk_q(1'b0);
        drive(1'b1);
        cyc(2 * TC);
        drive(1'b0);
        cyc(8);
        chk_cnt('0);
        on_run(hs);
        drive(1'b0);
        cyc(8);
        for (int i = 0; i < tbl.size(); i += 6) begin
            set_hi(tbl[i], tbl[i+1], tbl[i+2], tbl[i+3], tbl[i+4],
                   tbl[i+5]);
            on_run(hs);
            drive(1'b0);
            cyc(8);
        end
        @(posedge ref_clk);
        mode_sel <= MODE_OFF;
        set_hi(0, 0, 0, 6, 0, 0);
        drive(1'b1);
        cyc(8);
        chk_q(1'b1);
        drive(1'b0);
        cyc(8);
        chk_q(1'b1);
        cyc((hs - 1) * TC - 8);
        chk_q(1'b1);
        cyc(TC + 8);
        chk_q(1'b0);
        drive(1'b1);
        cyc(8);
        drive(1'b0);
        cyc(2 * TC);
        drive(1'b1);
        cyc(4);
        drive(1'b0);
        cyc((hs - 1) * TC);
        chk_q(1'b1);
        cyc(TC + 8);
        chk_q(1'b0);
        drive(1'b1);
        cyc(8);
        drive(1'b0);
        cyc(TC);
        clear_in <= 1'b1;
        cyc(8);
        chk_q(1'b0);
        chk_cnt('0);
        @(posedge ref_clk);
        clear_in <= 1'b0;
        mode_sel <= MODE_ONOFF;
        set_hi(0, 0, 0, 4, 0, 0);
        drive(1'b1);
        cyc(2 * TC);
        drive(1'b0);
        cyc(8);
        chk_cnt('0);
        cyc((hs + 1) * TC);
        chk_q(1'b0);
        on_run(hs);
        drive(1'b0);
        cyc(2 * TC);
        drive(1'b1);
        cyc((ls + 1) * TC);
        chk_q(1'b1);
        drive(1'b0);
        cyc((ls - 1) * TC);
        chk_q(1'b1);
        cyc(TC + 8);
        chk_q(1'b0);
        @(posedge ref_clk);
        mode_sel <= MODE_ON;
        set_hi(0, 0, 0, 10, 0, 0);
        // retention lets the frozen count finish well before a full span
        for (int r = 0; r < 2; r++) begin
            retain_sel <= retain_t'(r[0]);
            drive(1'b1);
            cyc(6 * TC);
            power_fail_in <= 1'b1;
            cyc(40);
            power_fail_in <= 1'b0;
            cyc(8);
            if (r == 0) chk_cnt('0);
            cyc(6 * TC);
            chk_q(r[0]);
            drive(1'b0);
            cyc(8);
        end
        test_done();
    end
endmodule
`default_nettype wire
